/* include/ldc_map.svh */
/*
  Register map and bit positions of the LIN data and command register slice.
  Assumes an APB slave with one aligned 32-bit word per register; index times four
  gives the byte address.
*/
// What this block does
// [RULE1] Eight byte-wide read/write frame data buffers at indices 0x00-0x07, reset zero.
// [RULE2] Command/control register at index 0x08, all bits reset to zero.
// [RULE3] Slave: writing one to bit 7 halts processing until next break; reads zero.
// [RULE4] Slave: bit 6 set sleeps after sleep frame or idle timeout; clear wakes.
// [RULE5] Bit 5 selects frame direction: zero receive, one transmit.
// [RULE6] Slave: software sets bit 4 to acknowledge data request; hardware clears it.
// [RULE7] Writing one to bit 3 clears interrupt pending flag; bit reads zero.
// [RULE8] Writing one to bit 2 clears status and error register errors; reads zero.
// [RULE9] Bit 1 sends a wakeup signal ending sleep, then clears automatically.
// [RULE10] Master: setting bit 0 launches a LIN frame transmission.
// [RULE11] Software loads identifier, length and data before setting start request.
// [RULE12] Start request returns to zero on transmission completion or error.
// [RULE13] Master-only bits act only in master mode, slave-only bits only in slave.
// [RULE14] Status bit 3 shows pending interrupt until cleared by clear command.
// [RULE15] Slave: status bit 4 set when data identifier received.
// [RULE16] Status bit 0 cleared on transmission start, set when transmission completes.
`ifndef LDC_MAP_SVH
`define LDC_MAP_SVH
`define LDC_IDX_DATA_LAST 4'h7
`define LDC_IDX_CTRL 4'h8
`define LDC_IDX_STATUS 4'h9
`define LDC_IDX_ERR 4'ha
`define LDC_IDX_MODE 4'hb
`define LDC_BIT_HALT 7
`define LDC_BIT_SLEEP 6
`define LDC_BIT_DIR 5
`define LDC_BIT_ACK 4
`define LDC_BIT_CLRINT 3
`define LDC_BIT_CLRERR 2
`define LDC_BIT_WAKE 1
`define LDC_BIT_START 0
`define LDC_BIT_MASTER 0
`define LDC_ST_DREQ 4
`define LDC_ST_INT 3
`define LDC_ST_ERR 2
`define LDC_ST_DONE 0
`define LDC_RESET_BYTE 8'h00
`define LDC_CTRL_RW_MASK 8'h73
`endif

/* include/ldc_pkg.sv */
/*
  Types shared by the register slice and its data store.
  Assumes nothing beyond the map header.
*/
package ldc_pkg;
  typedef logic [7:0] ldc_byte_t;
  typedef enum logic [2:0] {
    LDC_IDLE = 3'b001,
    LDC_SETUP = 3'b010,
    LDC_ACCESS = 3'b100
  } ldc_apb_state_t;
endpackage : ldc_pkg

/* hw/ldc_data_store.sv */
/*
  Eight frame data bytes, written from software or from the frame engine.
  Assumes engine writes never coincide with software writes to the same byte;
  the engine wins when they do, since it owns bus timing.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ldc_map.svh"
module ldc_data_store (
  input wire logic core_clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic sw_we_in, // Software write strobe
  input wire logic [2:0] sw_idx_in, // Software byte index
  input wire logic [7:0] sw_data_in, // Software write data
  input wire logic eng_we_in, // Engine write strobe
  input wire logic [2:0] eng_idx_in, // Engine byte index
  input wire logic [7:0] eng_data_in, // Engine write data
  output logic [63:0] bytes_out // All eight bytes, byte 0 lowest
);
  ldc_pkg::ldc_byte_t mem [0:7];
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_byte
      wire logic eng_hit = eng_we_in && (eng_idx_in == 3'(g));
      wire logic sw_hit = sw_we_in && (sw_idx_in == 3'(g));
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          mem[g] <= `LDC_RESET_BYTE; // RULE1
        end else if (eng_hit) begin
          mem[g] <= eng_data_in;
        end else if (sw_hit) begin
          mem[g] <= sw_data_in; // RULE1
        end
      end
      assign bytes_out[g*8 +: 8] = mem[g];
    end
  endgenerate
endmodule // ldc_data_store
`default_nettype wire

/* hw/ldc_regs.sv */
/*
  APB register slice of a LIN controller: frame data buffers, command/control,
  read views of status and error flags, and a writable mode register.
  Assumes the frame engine is on the same clock and gives one-cycle event pulses.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ldc_map.svh"
module ldc_regs (
  input wire logic core_clk_in, // System clock, 250 MHz
  input wire logic rst_in, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic eng_tx_start_in, // Engine: transmission started
  input wire logic eng_tx_done_in, // Engine: transmission completed
  input wire logic eng_err_in, // Engine: error detected
  input wire logic [7:0] eng_err_bits_in, // Engine: error causes
  input wire logic eng_irq_in, // Engine: interrupt event
  input wire logic eng_dreq_in, // Engine: data identifier received
  input wire logic eng_ack_taken_in, // Engine: acknowledge consumed
  input wire logic eng_break_in, // Engine: break field seen
  input wire logic eng_wake_sent_in, // Engine: wakeup signal sent
  input wire logic eng_we_in, // Engine data byte write
  input wire logic [2:0] eng_idx_in, // Engine data byte index
  input wire logic [7:0] eng_data_in, // Engine data byte
  output logic [63:0] frame_bytes_out, // Data buffers to engine
  output logic frame_direction_out, // One: transmit frame
  output logic sleep_select_out, // Sleep request level
  output logic halted_out, // Processing halted until break
  output logic start_request_out, // Start frame level
  output logic wakeup_request_out, // Send wakeup level
  output logic data_ack_out, // Data request acknowledged
  output logic interrupt_pending_out, // Pending interrupt flag
  output logic error_out // Error flag
);
  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  ldc_pkg::ldc_apb_state_t state, next_state;
  wire logic [3:0] idx = paddr[5:2];
  wire logic word_ok = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
  wire logic is_data = word_ok && (idx <= `LDC_IDX_DATA_LAST);
  wire logic is_ctrl = word_ok && (idx == `LDC_IDX_CTRL);
  wire logic is_stat = word_ok && (idx == `LDC_IDX_STATUS);
  wire logic is_err = word_ok && (idx == `LDC_IDX_ERR);
  wire logic is_mode = word_ok && (idx == `LDC_IDX_MODE);
  wire logic mapped = is_data || is_ctrl || is_stat || is_err || is_mode;
  // State lags the bus by a cycle: SETUP here means the setup cycle has just ended
  wire logic access = psel && penable && (state == ldc_pkg::LDC_SETUP);
  // Read-only words refuse writes so software sees the mistake
  wire logic bad = !mapped || (pwrite && (is_stat || is_err));
  wire logic wr = access && pwrite && !bad;
  wire logic wr_data = wr && is_data;
  wire logic wr_ctrl = wr && is_ctrl;
  wire logic wr_mode = wr && is_mode;
  wire logic [7:0] wb = pwdata[7:0];

  always_comb begin
    next_state = state;
    case (state)
      ldc_pkg::LDC_IDLE: if (psel && !penable) next_state = ldc_pkg::LDC_SETUP;
      ldc_pkg::LDC_SETUP: next_state = ldc_pkg::LDC_ACCESS;
      ldc_pkg::LDC_ACCESS: next_state = (psel && !penable) ? ldc_pkg::LDC_SETUP
                                                           : ldc_pkg::LDC_IDLE;
      default: next_state = ldc_pkg::LDC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) state <= ldc_pkg::LDC_IDLE;
    else state <= next_state;
  end

  // Zero wait states: access phase always completes in one cycle
  assign pready = 1'b1;
  assign pslverr = access && bad;

  // ----------------------------------------------------------------
  // Mode and control
  // ----------------------------------------------------------------
  logic master_mode;
  logic [7:0] ctrl;
  logic halted;
  logic dreq;
  logic irq;
  logic err;
  logic done;
  logic [7:0] err_bits;

  wire logic slave_mode = !master_mode;
  wire logic set_halt = wr_ctrl && wb[`LDC_BIT_HALT] && slave_mode; // RULE3 RULE13
  wire logic do_clrint = wr_ctrl && wb[`LDC_BIT_CLRINT]; // RULE7
  wire logic do_clrerr = wr_ctrl && wb[`LDC_BIT_CLRERR]; // RULE8

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) master_mode <= 1'b0;
    else if (wr_mode) master_mode <= wb[`LDC_BIT_MASTER];
  end

  // Stored bits: sleep, direction, ack, wakeup, start
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= `LDC_RESET_BYTE; // RULE2
    end else begin
      if (wr_ctrl) begin
        ctrl[`LDC_BIT_DIR] <= wb[`LDC_BIT_DIR]; // RULE5
        if (slave_mode) ctrl[`LDC_BIT_SLEEP] <= wb[`LDC_BIT_SLEEP]; // RULE4 RULE13
      end
      // Hardware clear loses to a fresh software set in the same cycle
      if (wr_ctrl && slave_mode && wb[`LDC_BIT_ACK]) ctrl[`LDC_BIT_ACK] <= 1'b1; // RULE6
      else if (eng_ack_taken_in) ctrl[`LDC_BIT_ACK] <= 1'b0; // RULE6
      if (wr_ctrl && wb[`LDC_BIT_WAKE]) ctrl[`LDC_BIT_WAKE] <= 1'b1; // RULE9
      else if (eng_wake_sent_in) ctrl[`LDC_BIT_WAKE] <= 1'b0; // RULE9
      if (wr_ctrl && master_mode && wb[`LDC_BIT_START]) begin
        ctrl[`LDC_BIT_START] <= 1'b1; // RULE10 RULE13
      end else if (eng_tx_done_in || eng_err_in) begin
        ctrl[`LDC_BIT_START] <= 1'b0; // RULE12
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) halted <= 1'b0;
    else if (set_halt) halted <= 1'b1; // RULE3
    else if (eng_break_in) halted <= 1'b0; // RULE3
  end

  // ----------------------------------------------------------------
  // Status flags: an event in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq <= 1'b0;
      err <= 1'b0;
      err_bits <= `LDC_RESET_BYTE;
      dreq <= 1'b0;
      done <= 1'b0;
    end else begin
      if (eng_irq_in) irq <= 1'b1; // RULE14
      else if (do_clrint) irq <= 1'b0; // RULE7 RULE14
      if (eng_err_in) err <= 1'b1;
      else if (do_clrerr) err <= 1'b0; // RULE8
      err_bits <= (do_clrerr ? `LDC_RESET_BYTE : err_bits) | eng_err_bits_in; // RULE8
      if (eng_dreq_in && slave_mode) dreq <= 1'b1; // RULE15
      else if (ctrl[`LDC_BIT_ACK] && eng_ack_taken_in) dreq <= 1'b0;
      if (eng_tx_done_in) done <= 1'b1; // RULE16
      else if (eng_tx_start_in) done <= 1'b0; // RULE16
    end
  end

  // ----------------------------------------------------------------
  // Data buffers
  // ----------------------------------------------------------------
  logic [63:0] bytes;
  ldc_data_store u_store (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .sw_we_in(wr_data),
    .sw_idx_in(idx[2:0]),
    .sw_data_in(wb),
    .eng_we_in(eng_we_in),
    .eng_idx_in(eng_idx_in),
    .eng_data_in(eng_data_in),
    .bytes_out(bytes)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Write-only command bits are absent from the stored byte and read zero
  wire logic [7:0] ctrl_rd = ctrl & `LDC_CTRL_RW_MASK; // RULE3 RULE7 RULE8
  logic [7:0] stat_rd;
  always_comb begin
    stat_rd = `LDC_RESET_BYTE;
    stat_rd[`LDC_ST_DREQ] = dreq; // RULE15
    stat_rd[`LDC_ST_INT] = irq; // RULE14
    stat_rd[`LDC_ST_ERR] = err; // RULE8
    stat_rd[`LDC_ST_DONE] = done; // RULE16
  end
  wire logic [7:0] data_rd = bytes[idx[2:0]*8 +: 8];
  wire logic [7:0] rd_byte = is_data ? data_rd :
                             is_ctrl ? ctrl_rd :
                             is_stat ? stat_rd :
                             is_err ? err_bits :
                             is_mode ? {7'h0, master_mode} : 8'h00;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= {24'h00_0000, rd_byte};
  end

  assign frame_bytes_out = bytes;
  assign frame_direction_out = ctrl[`LDC_BIT_DIR];
  assign sleep_select_out = ctrl[`LDC_BIT_SLEEP];
  assign halted_out = halted;
  assign start_request_out = ctrl[`LDC_BIT_START];
  assign wakeup_request_out = ctrl[`LDC_BIT_WAKE];
  assign data_ack_out = ctrl[`LDC_BIT_ACK];
  assign interrupt_pending_out = irq;
  assign error_out = err;
endmodule // ldc_regs
`default_nettype wire

/* tb/ldc_regs_asserts.sv */
/* Port assertions for the LIN data and command slice.
   Assumes one clock and control at byte address 0x20. */
`timescale 1ns/10ps
`default_nettype none
module ldc_regs_asserts (
  input wire logic core_clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic eng_irq_in, // Irq event
  input wire logic eng_err_in, // Error event
  input wire logic eng_tx_done_in, // Frame done
  input wire logic eng_wake_sent_in, // Wakeup sent
  input wire logic eng_we_in, // Engine write
  input wire logic [63:0] frame_bytes_out, // Data bytes
  input wire logic frame_direction_out, // Direction
  input wire logic start_request_out, // Start
  input wire logic wakeup_request_out, // Wakeup
  input wire logic interrupt_pending_out, // Irq flag
  input wire logic error_out // Error flag
);
  // --------
  // Properties
  // --------
  wire wr = psel && penable && pwrite;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_wr(a); wr && paddr == a; endsequence
  property p_data; s_wr(8'h00) ##0 !eng_we_in |=> frame_bytes_out[7:0] == $past(pwdata[7:0]);
  endproperty
  a_data: assert property (p_data) else $error("data byte");
  property p_dir; s_wr(8'h20) |=> frame_direction_out == $past(pwdata[5]); endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_int_set; $rose(interrupt_pending_out) |-> $past(eng_irq_in); endproperty
  a_int_set: assert property (p_int_set) else $error("irq set");
  property p_int_clr; s_wr(8'h20) ##0 (pwdata[3] && !eng_irq_in) |=> !interrupt_pending_out;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("irq clear");
  property p_err_clr; s_wr(8'h20) ##0 (pwdata[2] && !eng_err_in) |=> !error_out; endproperty
  a_err_clr: assert property (p_err_clr) else $error("error clear");
  property p_start_set; $rose(start_request_out) |-> $past(wr && paddr == 8'h20 && pwdata[0]);
  endproperty
  a_start_set: assert property (p_start_set) else $error("start set");
  property p_start_clr; start_request_out && (eng_tx_done_in || eng_err_in) && !wr
    |=> !start_request_out; endproperty
  a_start_clr: assert property (p_start_clr) else $error("start clear");
  property p_wake_clr; wakeup_request_out && eng_wake_sent_in && !wr |=> !wakeup_request_out;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wakeup clear");
endmodule // ldc_regs_asserts
bind ldc_regs ldc_regs_asserts u_chk (.core_clk_in, .rst_in, .psel, .penable, .pwrite, .paddr,
  .pwdata, .eng_irq_in, .eng_err_in, .eng_tx_done_in, .eng_wake_sent_in, .eng_we_in,
  .frame_bytes_out, .frame_direction_out, .start_request_out, .wakeup_request_out,
  .interrupt_pending_out, .error_out);
`default_nettype wire

/* tb/ldc_engine_model.sv */
/* Frame engine stand-in that answers the ack, wakeup, halt and start levels.
   Assumes the slice's clock; latency is fixed at a few cycles. */
`timescale 1ns/10ps
`default_nettype none
module ldc_engine_model (
  input wire logic core_clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic ack_in, // Ack level
  input wire logic wake_in, // Wakeup level
  input wire logic halt_in, // Halt level
  input wire logic start_in, // Start level
  output logic ack_taken_out, // Ack used
  output logic wake_sent_out, // Wakeup sent
  output logic break_out, // Break seen
  output logic tx_start_out, // Frame began
  output logic tx_done_out // Frame ended
);
  // --------
  // Delay lines
  // --------
  // Slow answers leave software time to read the levels back
  logic [8:0] ha, hw, hh, hs;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) {ha, hw, hh, hs} <= '0;
    else {ha, hw, hh, hs} <= {ha[7:0], ack_in, hw[7:0], wake_in, hh[7:0], halt_in, hs[7:0],
      start_in};
  end
  assign ack_taken_out = ha[7] & ~ha[8];
  assign wake_sent_out = hw[7] & ~hw[8];
  assign break_out = hh[7] & ~hh[8];
  assign tx_start_out = hs[1] & ~hs[2];
  assign tx_done_out = hs[7] & ~hs[8];
endmodule // ldc_engine_model
`default_nettype wire

/* tb/test_ldc_regs.sv */
/* Self-checking bench for the LIN data and command slice.
   Assumes the engine stand-in and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_ldc_regs;
  logic core_clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, serr;
  logic [7:0] paddr = 8'h00, eng_err_bits_in = 8'h00, eng_data_in = 8'h00, d, eb;
  logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'h00015ad2;
  logic eng_err_in = 0, eng_irq_in = 0, eng_dreq_in = 0, eng_we_in = 0;
  logic [2:0] eng_idx_in = 3'h0;
  logic [63:0] fb;
  logic ts, td, ak, br, ws, dir, slp, hlt, st, wk, ack, ip, er;
  int n_mismatch = 0, total_checks = 0, i;
  always #2 core_clk_in = ~core_clk_in;
  ldc_regs dut (.core_clk_in, .rst_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .eng_tx_start_in(ts), .eng_tx_done_in(td), .eng_err_in, .eng_err_bits_in,
    .eng_irq_in, .eng_dreq_in, .eng_ack_taken_in(ak), .eng_break_in(br), .eng_wake_sent_in(ws),
    .eng_we_in, .eng_idx_in, .eng_data_in, .frame_bytes_out(fb), .frame_direction_out(dir),
    .sleep_select_out(slp), .halted_out(hlt), .start_request_out(st), .wakeup_request_out(wk),
    .data_ack_out(ack), .interrupt_pending_out(ip), .error_out(er));
  ldc_engine_model eng (.core_clk_in, .rst_in, .ack_in(ack), .wake_in(wk), .halt_in(hlt),
    .start_in(st), .ack_taken_out(ak), .wake_sent_out(ws), .break_out(br), .tx_start_out(ts),
    .tx_done_out(td));
  // --------
  // Helpers
  // --------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_ctrl(input logic [7:0] v, input logic m);
    return {24'h0, v & (m ? 8'h23 : 8'h72)};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk_in);
    penable <= 1;
    k = 0;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      wrap_up;
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk_in);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_mismatch++;
    wrap_up;
  end
  // --------
  // Scenarios
  // --------
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_in <= 0;
    @(posedge core_clk_in);
    for (i = 0; i < 9; i++) begin
      apb(0, 8'(i * 4), 0);
      chk(rdat, 0);
    end
    for (i = 0; i < 8; i++) begin
      d = 8'(rnd());
      apb(1, 8'(i * 4), {24'h0, d});
      apb(0, 8'(i * 4), 0);
      chk(rdat, {24'h0, d});
      chk(fb[i*8 +: 8], d);
    end
    apb(0, 8'h30, 0);
    chk({serr, rdat[30:0]}, 32'h80000000);
    d = 8'(rnd());
    eng_we_in <= 1;
    eng_idx_in <= 3'h3;
    eng_data_in <= d;
    @(posedge core_clk_in);
    eng_we_in <= 0;
    @(posedge core_clk_in);
    chk(fb[31:24], d);
    for (i = 0; i < 5; i++) begin
      d = (i == 0) ? 8'hff : 8'(rnd());
      apb(1, 8'h20, {24'h0, d});
      chk({hlt, slp, dir, st}, {d[7:5], 1'b0});
      apb(0, 8'h20, 0);
      chk(rdat, exp_ctrl(d, 0));
      repeat (12) @(posedge core_clk_in);
      chk({hlt, ack, wk}, 0);
    end
    eb = 8'(rnd());
    {eng_irq_in, eng_err_in, eng_dreq_in, eng_err_bits_in} <= {3'h7, eb};
    @(posedge core_clk_in);
    {eng_irq_in, eng_err_in, eng_dreq_in, eng_err_bits_in} <= 11'h0;
    @(posedge core_clk_in);
    apb(0, 8'h24, 0);
    chk({ip, er, rdat[4:2]}, 5'h1f);
    apb(1, 8'h24, 0);
    chk({serr, ip, er}, 3'h7);
    apb(0, 8'h28, 0);
    chk(rdat, {24'h0, eb});
    apb(1, 8'h20, 32'h1c);
    apb(0, 8'h28, 0);
    chk({ip, er, rdat[29:0]}, 0);
    repeat (12) @(posedge core_clk_in);
    apb(0, 8'h24, 0);
    chk(rdat[4:2], 0);
    apb(1, 8'h2c, 1);
    for (i = 0; i < 2; i++) begin
      d = 8'(rnd() | 1);
      apb(1, 8'h20, {24'h0, d});
      chk({dir, hlt, ack, st}, {d[5], 3'h1});
      if (i == 1) begin
        eng_err_in <= 1;
        @(posedge core_clk_in);
        eng_err_in <= 0;
        @(posedge core_clk_in);
        chk(st, 0);
      end
      apb(0, 8'h20, 0);
      chk(rdat, exp_ctrl(d, 1) & ~32'(i));
      apb(0, 8'h24, 0);
      chk(rdat[0], 0);
      repeat (10) @(posedge core_clk_in);
      apb(0, 8'h24, 0);
      chk({st, rdat[0]}, 1);
    end
    wrap_up;
  end
endmodule // test_ldc_regs
`default_nettype wire
